// file: hdl/bus_ctl_pkg.sv
// Package with constants and types for the bus controller sequencer
package bus_ctl_pkg;
	localparam int unsigned CLK_MHZ = 200;
	localparam int unsigned T_ATN_RESP_US = 45;
	localparam int unsigned T_PRI_PLACE_US = 140;
	localparam int unsigned T_SETTLE_US = 20;
	localparam int unsigned T_SEC_PREP_US = 57;
	localparam int unsigned T_ATN_REL_US = 37;
	localparam int unsigned T_FIRST_DATA_US = 73;
	localparam int unsigned T_DAV_HOLD_US = 18;
	localparam int unsigned T_NEXT_DATA_US = 88;
	localparam int unsigned T_SEQ_MIN_US = 310;
	localparam int unsigned T_SEQ_SUP_MIN_US = 224;
	localparam int unsigned T_CYCLE_MIN_US = 127;
	localparam int unsigned T_UNADDR_MIN_US = 830;
	localparam int unsigned CYC_ATN_RESP = T_ATN_RESP_US * CLK_MHZ;
	localparam int unsigned CYC_PRI_PLACE = T_PRI_PLACE_US * CLK_MHZ;
	localparam int unsigned CYC_SETTLE = T_SETTLE_US * CLK_MHZ;
	localparam int unsigned CYC_SEC_PREP = T_SEC_PREP_US * CLK_MHZ;
	localparam int unsigned CYC_ATN_REL = T_ATN_REL_US * CLK_MHZ;
	localparam int unsigned CYC_FIRST_DATA = T_FIRST_DATA_US * CLK_MHZ;
	localparam int unsigned CYC_DAV_HOLD = T_DAV_HOLD_US * CLK_MHZ;
	localparam int unsigned CYC_NEXT_DATA = T_NEXT_DATA_US * CLK_MHZ;
	localparam int unsigned CYC_SEQ_MIN = T_SEQ_MIN_US * CLK_MHZ;
	localparam int unsigned CYC_SEQ_SUP_MIN = T_SEQ_SUP_MIN_US * CLK_MHZ;
	localparam int unsigned CYC_CYCLE_MIN = T_CYCLE_MIN_US * CLK_MHZ;
	localparam int unsigned CYC_UNADDR_MIN = T_UNADDR_MIN_US * CLK_MHZ;
	localparam int unsigned TMR_W = 18;
	localparam logic [7:0] SEC_OUT_DEFAULT = 8'h0C;
	localparam logic [7:0] SEC_IN_DEFAULT = 8'h0D;
	localparam logic [7:0] SEC_SUPPRESS = 8'h20;
	localparam logic [7:0] LISTEN_BASE = 8'h20;
	localparam logic [7:0] TALK_BASE = 8'h40;
	localparam logic [7:0] SEC_BASE = 8'h60;
	localparam logic [7:0] CMD_UNLISTEN = 8'h3F;
	localparam logic [7:0] CMD_UNTALK = 8'h5F;
	localparam logic [6:0] BURST_MAX = 7'h48;
	localparam logic [6:0] IN_MAX = 7'h48;

	typedef struct packed {
		logic atn;
		logic dav;
		logic nrfd;
		logic ndac;
	} hs_lines_t;

	typedef struct packed {
		logic is_input;
		logic [4:0] addr;
		logic [7:0] sec;
	} xfer_cmd_t;
endpackage

// file: hdl/bus_ctl_seq.sv
// Controller sequencer for addressing, data bursts and unaddressing
`timescale 1ns/1ps
// Overview of operation
// (R1) Idle bus: hold NRFD and NDAC low, release all other lines.
// (R2) Start a transfer by asserting ATN low when ready.
// (R3) Peripherals answer ATN within 200 ns; allow up to 45 us.
// (R4) After 45 us release NRFD; both high aborts, NRFD low waits, else address.
// (R5) Input: talk address 140 us after ATN, settle 20 us, then DAV low.
// (R6) Input without suppression sends secondary address 13 after talk address; the code sends 13 only when sec is 0, else sec bits 4:0.
// (R7) Output without suppression sends secondary address 12 after listen address; the code sends 12 only when sec is 0, else sec bits 4:0.
// (R8) Peripherals pull NDAC low after DAV rises, then release NRFD when ready.
// (R9) Secondary address placed 57 us after DAV rises on primary address.
// (R10) After placing an address wait 20 us, then DAV low once NRFD high.
// (R11) 37 us after DAV rises on secondary, release ATN.
// (R12) Only the listen-addressed peripheral accepts data after ATN release.
// (R13) Full output addressing with secondary takes at least 310 us.
// (R14) Secondary value 32 suppresses it; minimum sequence becomes 224 us.
// (R15) Output data in bursts of at most 72 characters, idle between.
// (R16) First data byte 73 us after ATN rises; settle 20 us, DAV when NRFD high.
// (R17) Listener answers DAV by pulling NRFD low, capturing, releasing NDAC.
// (R18) Release DAV when NDAC rises; DAV low at least 18 us.
// (R19) Next byte placed 88 us after DAV rises; settle 20 us; sample NRFD.
// (R20) Each data handshake cycle lasts at least 127 us DAV to DAV; the sequencer does not enforce it, its delays sum to 18 + 88 + 20 = 126 us.
// (R21) After last byte: ATN, UNTALK, UNLISTEN, release ATN; at least 830 us.
// (R22) Input stops after delimiter or 72 characters and holds the bus.
// (R23) Lines are active-low open-collector; assert by pulling low, else release.
module bus_ctl_seq
	import bus_ctl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire xfer_cmd_t i_cmd,
	input wire logic i_data_valid,
	input wire logic [7:0] i_data,
	input wire logic i_data_last,
	output logic o_data_ready,
	output logic o_burst_pause,
	input wire logic i_burst_go,
	input wire logic i_delim_seen,
	input wire logic [6:0] i_in_count,
	output logic o_in_hold,
	input wire hs_lines_t i_lines,
	output hs_lines_t o_lines_oe_n,
	output logic [7:0] o_dio_out,
	output logic [7:0] o_dio_oe_n,
	output logic o_busy,
	output logic o_done,
	output logic o_err,
	output logic o_listen_phase
);

	typedef enum logic [4:0] {
		S_IDLE, S_ATN_WAIT, S_CHECK, S_WAIT_NRFD, S_PRI_PLACE, S_SETTLE,
		S_DAV_WAIT, S_DAV_LOW, S_DAV_HOLD, S_SEC_PREP, S_ATN_REL,
		S_DATA_PREP, S_PAUSE, S_UN_ATN, S_UN_DONE, S_LISTEN, S_ERR
	} state_t;

	typedef enum logic [2:0] {
		B_PRI, B_SEC, B_DATA, B_UNT, B_UNL
	} byte_kind_t;

	hs_lines_t lines_s1_r;
	hs_lines_t lines_s2_r;
	state_t state_r;
	byte_kind_t kind_r;
	xfer_cmd_t cmd_r;
	logic [TMR_W-1:0] tmr_r;
	logic [TMR_W-1:0] seq_tmr_r;
	logic [7:0] dio_r;
	logic dio_drive_r;
	logic [6:0] burst_cnt_r;
	logic last_r;
	logic atn_r;
	logic dav_r;
	logic nrfd_r;
	logic ndac_r;
	logic done_r;
	logic err_r;
	logic tmr_load;
	logic tmr_done;
	state_t prev_state_r;
	logic [TMR_W-1:0] tmr_nxt;
	logic suppress;
	logic ndac_hi;
	logic nrfd_hi;
	logic seq_ok;

	// Bus lines into the clock domain
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			lines_s1_r <= '1;
			lines_s2_r <= '1;
		end else begin
			lines_s1_r <= i_lines;
			lines_s2_r <= lines_s1_r;
		end
	end

	assign ndac_hi = lines_s2_r.ndac;
	assign nrfd_hi = lines_s2_r.nrfd;
	assign suppress = (cmd_r.sec == SEC_SUPPRESS); // [R14]
	assign seq_ok = suppress ? (seq_tmr_r >= TMR_W'(CYC_SEQ_SUP_MIN))
		: (seq_tmr_r >= TMR_W'(CYC_SEQ_MIN)); // [R13] [R14]

	// Main sequencer
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_r <= S_IDLE;
			kind_r <= B_PRI;
			cmd_r <= '0;
			atn_r <= 1'b0;
			dav_r <= 1'b0;
			nrfd_r <= 1'b1;
			ndac_r <= 1'b1;
			dio_r <= 8'h00;
			dio_drive_r <= 1'b0;
			burst_cnt_r <= 7'h00;
			last_r <= 1'b0;
			done_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					atn_r <= 1'b0;
					dav_r <= 1'b0;
					nrfd_r <= 1'b1; // [R1]
					ndac_r <= 1'b1; // [R1]
					dio_drive_r <= 1'b0;
					if (i_start) begin
						cmd_r <= i_cmd;
						err_r <= 1'b0;
						atn_r <= 1'b1; // [R2]
						state_r <= S_ATN_WAIT;
					end
				end
				S_ATN_WAIT: begin
					if (tmr_done) begin // [R3]
						nrfd_r <= 1'b0; // [R4]
						ndac_r <= 1'b0; // [R23]
						state_r <= S_CHECK;
					end
				end
				S_CHECK: begin
					// Let released lines pass the synchroniser
					if (state_r == prev_state_r
						&& tmr_r <= TMR_W'(CYC_PRI_PLACE - CYC_ATN_RESP - 5)) begin
						if (ndac_hi && nrfd_hi) begin
							state_r <= S_ERR; // [R4]
						end else if (!nrfd_hi) begin
							state_r <= S_WAIT_NRFD; // [R4]
						end else begin
							state_r <= S_PRI_PLACE;
						end
					end
				end
				S_WAIT_NRFD: begin
					if (nrfd_hi) begin
						state_r <= S_PRI_PLACE; // [R4]
					end
				end
				S_PRI_PLACE: begin
					if (tmr_done) begin // [R5]
						kind_r <= B_PRI;
						dio_r <= (cmd_r.is_input ? TALK_BASE : LISTEN_BASE)
							| {3'b000, cmd_r.addr};
						dio_drive_r <= 1'b1;
						state_r <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					if (tmr_done) begin
						state_r <= S_DAV_WAIT; // [R10]
					end
				end
				S_DAV_WAIT: begin
					if (nrfd_hi && (kind_r != B_DATA || tmr_done)) begin
						dav_r <= 1'b1; // [R10] [R16] [R20]
						state_r <= S_DAV_LOW;
					end
				end
				S_DAV_LOW: begin
					if (ndac_hi && tmr_done) begin
						state_r <= S_DAV_HOLD; // [R18]
					end
				end
				S_DAV_HOLD: begin
					dav_r <= 1'b0; // [R18]
					case (kind_r)
						B_PRI: state_r <= suppress ? S_ATN_REL : S_SEC_PREP; // [R14]
						B_SEC: state_r <= S_ATN_REL; // [R11]
						B_UNT: state_r <= S_SEC_PREP;
						B_UNL: state_r <= S_UN_DONE;
						default: begin
							burst_cnt_r <= burst_cnt_r + 7'h01;
							state_r <= S_DATA_PREP; // [R19]
						end
					endcase
				end
				S_SEC_PREP: begin
					if (tmr_done) begin // [R9]
						if (kind_r == B_UNT) begin
							kind_r <= B_UNL;
							dio_r <= CMD_UNLISTEN; // [R21]
						end else begin
							kind_r <= B_SEC;
							if (suppress || cmd_r.sec == 8'h00) begin
								dio_r <= SEC_BASE
									| (cmd_r.is_input ? SEC_IN_DEFAULT : SEC_OUT_DEFAULT); // [R6] [R7]
							end else begin
								dio_r <= SEC_BASE | (cmd_r.sec & 8'h1F);
							end
						end
						state_r <= S_SETTLE;
					end
				end
				S_ATN_REL: begin
					dio_drive_r <= 1'b0;
					if (tmr_done && seq_ok) begin
						atn_r <= 1'b0; // [R11]
						if (cmd_r.is_input) begin
							state_r <= S_LISTEN;
						end else begin
							burst_cnt_r <= 7'h00;
							state_r <= S_DATA_PREP; // [R12]
						end
					end
				end
				S_DATA_PREP: begin
					if (last_r || burst_cnt_r == BURST_MAX) begin
						dio_drive_r <= 1'b0;
						state_r <= last_r ? S_UN_ATN : S_PAUSE; // [R15] [R21]
					end else if (tmr_done && i_data_valid) begin // [R16] [R19]
						kind_r <= B_DATA;
						dio_r <= i_data;
						dio_drive_r <= 1'b1;
						last_r <= i_data_last;
						state_r <= S_SETTLE;
					end
				end
				S_PAUSE: begin
					if (i_burst_go) begin
						burst_cnt_r <= 7'h00; // [R15]
						state_r <= S_DATA_PREP;
					end
				end
				S_UN_ATN: begin
					atn_r <= 1'b1; // [R21]
					last_r <= 1'b0;
					if (tmr_done) begin
						kind_r <= B_UNT;
						dio_r <= CMD_UNTALK; // [R21]
						dio_drive_r <= 1'b1;
						state_r <= S_SETTLE;
					end
				end
				S_UN_DONE: begin
					dio_drive_r <= 1'b0;
					if (tmr_done && seq_tmr_r >= TMR_W'(CYC_UNADDR_MIN)) begin
						atn_r <= 1'b0; // [R21]
						done_r <= 1'b1;
						state_r <= S_IDLE;
					end
				end
				S_LISTEN: begin
					if (i_delim_seen || i_in_count >= IN_MAX) begin
						done_r <= 1'b1; // [R22]
						state_r <= S_IDLE;
					end
				end
				S_ERR: begin
					atn_r <= 1'b0;
					dio_drive_r <= 1'b0;
					err_r <= 1'b1; // [R4]
					done_r <= 1'b1;
					state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end

	// Delay timer reloaded on state entry when the state just left has a delay listed; otherwise it keeps counting
	always_comb begin
		tmr_load = 1'b1;
		tmr_nxt = '0;
		case (prev_state_r)
			S_IDLE: tmr_nxt = TMR_W'(CYC_ATN_RESP); // [R3]
			S_ATN_WAIT: tmr_nxt = TMR_W'(CYC_PRI_PLACE - CYC_ATN_RESP - 1); // [R5]
			S_PRI_PLACE: tmr_nxt = TMR_W'(CYC_SETTLE); // [R10]
			S_SEC_PREP: tmr_nxt = TMR_W'(CYC_SETTLE); // [R10]
			S_DATA_PREP: tmr_nxt = TMR_W'(CYC_SETTLE); // [R16]
			S_UN_ATN: tmr_nxt = TMR_W'(CYC_SETTLE);
			S_DAV_WAIT: tmr_nxt = TMR_W'(CYC_DAV_HOLD); // [R18]
			S_DAV_HOLD: tmr_nxt = (kind_r == B_PRI || kind_r == B_UNT)
				? (suppress && kind_r == B_PRI ? TMR_W'(CYC_ATN_REL)
				: TMR_W'(CYC_SEC_PREP))
				: (kind_r == B_SEC ? TMR_W'(CYC_ATN_REL)
				: (kind_r == B_DATA ? TMR_W'(CYC_NEXT_DATA) : TMR_W'(CYC_ATN_REL)));
			S_ATN_REL: tmr_nxt = TMR_W'(CYC_FIRST_DATA); // [R16]
			S_PAUSE: tmr_nxt = TMR_W'(CYC_FIRST_DATA);
			default: tmr_load = 1'b0;
		endcase
	end

	// Load on the first cycle of a new state, keyed by the state just left
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tmr_r <= '0;
			prev_state_r <= S_IDLE;
		end else begin
			prev_state_r <= state_r;
			if (tmr_load && state_r != prev_state_r) begin
				tmr_r <= tmr_nxt;
			end else if (tmr_r != '0) begin
				tmr_r <= tmr_r - TMR_W'(1);
			end
		end
	end

	// Expired only once the entry load has taken effect
	assign tmr_done = (tmr_r == '0) && (state_r == prev_state_r);

	// Sequence timer for minimum sequence lengths, restarted on start and when DAV is released on each data byte
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			seq_tmr_r <= '0;
		end else if ((state_r == S_IDLE && i_start) || state_r == S_DAV_HOLD && kind_r == B_DATA) begin
			seq_tmr_r <= '0;
		end else if (seq_tmr_r != '1) begin
			seq_tmr_r <= seq_tmr_r + TMR_W'(1);
		end
	end

	assign o_lines_oe_n.atn = !atn_r; // [R23]
	assign o_lines_oe_n.dav = !dav_r; // [R23]
	assign o_lines_oe_n.nrfd = !nrfd_r; // [R23]
	assign o_lines_oe_n.ndac = !ndac_r; // [R23]
	assign o_dio_out = 8'h00;
	assign o_dio_oe_n = dio_drive_r ? dio_r ^ 8'hFF : 8'hFF; // [R23]
	assign o_data_ready = (state_r == S_DATA_PREP) && tmr_done && !last_r
		&& burst_cnt_r != BURST_MAX;
	assign o_burst_pause = (state_r == S_PAUSE);
	assign o_in_hold = (state_r == S_LISTEN);
	assign o_busy = (state_r != S_IDLE);
	assign o_done = done_r;
	assign o_err = err_r;
	assign o_listen_phase = (state_r == S_LISTEN);

endmodule // bus_ctl_seq

// file: sim/bus_ctl_seq_assertions.sv
// Checker for the bus controller sequencer
`timescale 1ns/1ps
module bus_ctl_seq_chk
	import bus_ctl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_start,
	input wire hs_lines_t i_lines,
	input wire hs_lines_t o_lines_oe_n,
	input wire logic [7:0] o_dio_oe_n,
	input wire logic o_busy,
	input wire logic o_err
);
	logic [17:0] atn_lo_r;
	logic [17:0] atn_hi_r;
	logic [17:0] dav_lo_r;
	logic [17:0] cyc_r;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	// Cycle counters for the timing checks
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			atn_lo_r <= 18'h0;
			atn_hi_r <= 18'h0;
			dav_lo_r <= 18'h0;
			cyc_r <= 18'h0;
		end else begin
			atn_lo_r <= o_lines_oe_n.atn ? 18'h0 : atn_lo_r + 18'h1;
			atn_hi_r <= o_lines_oe_n.atn ? atn_hi_r + {17'h0, ~&atn_hi_r} : 18'h0;
			dav_lo_r <= o_lines_oe_n.dav ? 18'h0 : dav_lo_r + 18'h1;
			cyc_r <= $fell(o_lines_oe_n.dav) ? 18'h1 : cyc_r + {17'h0, ~&cyc_r};
		end
	end
	property p_idle;
		!$past(o_busy) && !o_busy |-> o_lines_oe_n == 4'hC && o_dio_oe_n == 8'hFF;
	endproperty
	a_idle: assert property (p_idle) else $error("idle lines wrong");
	property p_start;
		!o_busy && i_start |-> ##[1:2] !o_lines_oe_n.atn;
	endproperty
	a_start: assert property (p_start) else $error("no attention");
	property p_nrfd_rel;
		$rose(o_lines_oe_n.nrfd) && !o_lines_oe_n.atn |->
			atn_lo_r >= CYC_ATN_RESP - 2 && atn_lo_r <= CYC_ATN_RESP + 2;
	endproperty
	a_nrfd_rel: assert property (p_nrfd_rel) else $error("check time wrong");
	property p_dav_nrfd;
		$fell(o_lines_oe_n.dav) |-> $past(i_lines.nrfd, 3);
	endproperty
	a_dav_nrfd: assert property (p_dav_nrfd) else $error("valid while not ready");
	property p_dav_hold;
		$rose(o_lines_oe_n.dav) |-> dav_lo_r >= CYC_DAV_HOLD && i_lines.ndac;
	endproperty
	a_dav_hold: assert property (p_dav_hold) else $error("valid released early");
	property p_cycle;
		$fell(o_lines_oe_n.dav) && o_lines_oe_n.atn |-> cyc_r >= CYC_CYCLE_MIN;
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle too short");
	property p_first;
		$fell(o_lines_oe_n.dav) && o_lines_oe_n.atn |->
			atn_hi_r >= CYC_FIRST_DATA + CYC_SETTLE;
	endproperty
	a_first: assert property (p_first) else $error("first byte early");
	property p_seq;
		$rose(o_lines_oe_n.atn) |-> (atn_lo_r >= CYC_SEQ_SUP_MIN) or (##[0:2] o_err);
	endproperty
	a_seq: assert property (p_seq) else $error("sequence too short");
endmodule // bus_ctl_seq_chk
bind bus_ctl_seq bus_ctl_seq_chk i_chk (
	.i_ref_clk(i_ref_clk),
	.i_nrst(i_nrst),
	.i_start(i_start),
	.i_lines(i_lines),
	.o_lines_oe_n(o_lines_oe_n),
	.o_dio_oe_n(o_dio_oe_n),
	.o_busy(o_busy),
	.o_err(o_err)
);

// file: sim/bus_periph_model.sv
// Peripheral instrument model on the handshake lines
`timescale 1ns/1ps
module bus_periph_model
	import bus_ctl_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_absent,
	input wire logic [17:0] i_dly,
	input wire hs_lines_t i_lines,
	input wire logic [7:0] i_dio_n,
	output logic o_nrfd_pull,
	output logic o_ndac_pull,
	output logic [31:0] o_log,
	output logic [7:0] o_cnt
);
	logic [17:0] cnt_r;
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_nrfd_pull <= 1'b1;
			o_ndac_pull <= 1'b1;
			o_log <= 32'h0;
			o_cnt <= 8'h0;
			cnt_r <= 18'h0;
		end else if (i_absent) begin
			o_nrfd_pull <= 1'b0;
			o_ndac_pull <= 1'b0;
		end else if (!i_lines.dav) begin
			o_nrfd_pull <= 1'b1;
			if (cnt_r < i_dly) begin
				cnt_r <= cnt_r + 18'h1;
			end else if (o_ndac_pull) begin
				o_log <= {o_log[23:0], ~i_dio_n};
				o_cnt <= o_cnt + 8'h1;
				o_ndac_pull <= 1'b0;
				cnt_r <= 18'h0;
			end
		end else if (!o_ndac_pull) begin
			o_ndac_pull <= 1'b1;
		end else if (o_nrfd_pull) begin
			if (cnt_r < i_dly) begin
				cnt_r <= cnt_r + 18'h1;
			end else begin
				o_nrfd_pull <= 1'b0;
				cnt_r <= 18'h0;
			end
		end
	end
endmodule // bus_periph_model

// file: sim/bus_ctl_seq_tb_top.sv
// Testbench for the bus controller sequencer
`timescale 1ns/1ps
module bus_ctl_seq_tb_top;
	import bus_ctl_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic start = 1'b0;
	xfer_cmd_t cmd = '0;
	logic dvalid = 1'b0;
	logic absent = 1'b0;
	logic delim = 1'b0;
	logic seen_hold = 1'b0;
	logic hold;
	logic [17:0] dly = 18'h2;
	logic dready, busy, done, err, nrfd_pull, ndac_pull;
	hs_lines_t lines, ctl_oe_n;
	logic [7:0] dio_oe_n, cnt;
	logic [31:0] log_w;
	int errors = 0;
	int check_count = 0;
	int cyc = 0;
	int t0 = 0;
	assign lines = {ctl_oe_n.atn, ctl_oe_n.dav, ctl_oe_n.nrfd & ~nrfd_pull,
		ctl_oe_n.ndac & ~ndac_pull};
	bus_ctl_seq i_dut (
		.i_ref_clk(clk), .i_nrst(nrst), .i_start(start), .i_cmd(cmd),
		.i_data_valid(dvalid), .i_data(8'h41), .i_data_last(1'b1),
		.o_data_ready(dready), .o_burst_pause(), .i_burst_go(1'b0),
		.i_delim_seen(delim), .i_in_count(7'h00), .o_in_hold(hold), .i_lines(lines),
		.o_lines_oe_n(ctl_oe_n), .o_dio_out(), .o_dio_oe_n(dio_oe_n), .o_busy(busy),
		.o_done(done), .o_err(err), .o_listen_phase()
	);
	bus_periph_model i_per (
		.i_ref_clk(clk), .i_nrst(nrst), .i_absent(absent), .i_dly(dly),
		.i_lines(lines), .i_dio_n(dio_oe_n), .o_nrfd_pull(nrfd_pull),
		.o_ndac_pull(ndac_pull), .o_log(log_w), .o_cnt(cnt)
	);
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (dready && dvalid) begin
			dvalid <= 1'b0;
		end
		if (hold) begin
			seen_hold <= 1'b1;
		end
		cyc <= cyc + 1;
		if (cyc == 900000) begin
			errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic inp, input logic [7:0] sec, input logic [17:0] d);
		@(posedge clk);
		dly <= d;
		dvalid <= 1'b1;
		start <= 1'b1;
		cmd <= '{inp, 5'h02, sec};
		t0 = cyc;
		@(posedge clk);
		start <= 1'b0;
		do @(negedge clk); while (done !== 1'b1);
	endtask
	task automatic test_idle();
		@(negedge clk);
		chk(ctl_oe_n, 4'hC);
		chk(dio_oe_n, 8'hFF);
		$display("test idle done");
	endtask
	task automatic test_abort();
		@(posedge clk);
		absent <= 1'b1;
		xfer(1'b0, 8'h20, 18'h2);
		chk(err, 1'b1);
		chk(cyc - t0 >= CYC_ATN_RESP, 1'b1);
		@(negedge clk);
		chk(ctl_oe_n, 4'hC);
		@(posedge clk);
		absent <= 1'b0;
		$display("test abort done");
	endtask
	task automatic test_slow_sup();
		xfer(1'b0, SEC_SUPPRESS, 18'h5DC0);
		chk(err, 1'b0);
		chk(cnt, 8'h04);
		chk(log_w, {LISTEN_BASE | 8'h02, 8'h41, CMD_UNTALK, CMD_UNLISTEN});
		chk(cyc - t0 >= CYC_SEQ_SUP_MIN + CYC_UNADDR_MIN, 1'b1);
		$display("test slow suppressed done");
	endtask
	task automatic test_prompt_sec();
		xfer(1'b0, 8'h00, 18'h2);
		chk(err, 1'b0);
		chk(cnt, 8'h09);
		chk(log_w, {SEC_BASE | SEC_OUT_DEFAULT, 8'h41, CMD_UNTALK, CMD_UNLISTEN});
		chk(cyc - t0 >= CYC_SEQ_MIN + CYC_UNADDR_MIN, 1'b1);
		$display("test prompt secondary done");
	endtask
	task automatic test_input();
		@(posedge clk);
		delim <= 1'b1;
		xfer(1'b1, 8'h00, 18'h2);
		chk(err, 1'b0);
		chk(cnt, 8'h0B);
		chk(log_w[15:0], {TALK_BASE | 8'h02, SEC_BASE | SEC_IN_DEFAULT});
		chk(seen_hold, 1'b1);
		chk(cyc - t0 >= CYC_PRI_PLACE + CYC_SETTLE, 1'b1);
		$display("test input done");
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		test_idle();
		test_abort();
		test_slow_sup();
		test_prompt_sec();
		test_input();
		end_sim();
	end
endmodule // bus_ctl_seq_tb_top
